// ### pad_function_select_mux_bench.sv
// self-checking bench of the pad function mux over AHB-Lite
`timescale 1ns/10ps
`include "pfm_defines.svh"

module pad_function_select_mux_bench;
    logic clk, reset, hsel, hwrite, hready_out, hresp, pclk_out, pclk_oen, par_mode;
    logic lcd_clk, tv_clk;
    logic [1:0] htrans, strap, ddr_map;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, gd, gdo, gsense, q;
    logic [15:0] a_in, a_out, a_oen, a_fo, a_foe, a_fi, lcd, tv, a_far;
    logic [7:0] b_in, b_out, b_oen, f1o, f1oe, f1i, f2o, f2oe, f2i, b_far;
    logic [5:0] c_in, c_far, c_cap;
    int n_errors, n_tests, cycles;

    pfm_pad_mux uut (.CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready_out),
        .HRDATA(hrdata), .HREADYOUT(hready_out), .HRESP(hresp), .GPIO_DRIVE(gd),
        .GPIO_DRIVE_OEN(gdo), .GPIO_SENSE(gsense), .A_PAD_IN(a_in), .A_PAD_OUT(a_out),
        .A_PAD_OEN(a_oen), .A_FUNC_OUT(a_fo), .A_FUNC_OEN(a_foe), .A_FUNC_IN(a_fi),
        .LCD_PIXEL(lcd), .TV_PIXEL(tv), .B_PAD_IN(b_in), .B_PAD_OUT(b_out),
        .B_PAD_OEN(b_oen), .B_FN1_OUT(f1o), .B_FN1_OEN(f1oe), .B_FN1_IN(f1i),
        .B_FN2_OUT(f2o), .B_FN2_OEN(f2oe), .B_FN2_IN(f2i), .LCD_PIXEL_CLOCK(lcd_clk),
        .TV_PIXEL_CLOCK(tv_clk), .PCLK_PAD_OUT(pclk_out), .PCLK_PAD_OEN(pclk_oen),
        .PHY_PARALLEL_MODE(par_mode), .COMBO_PAD_IN(c_in), .COMBO_CAPTURE(c_cap),
        .PKG_MAP_STRAP(strap), .DDR_MAP(ddr_map));

    pfm_ball_model balls (.a_out(a_out), .a_oen(a_oen), .b_out(b_out), .b_oen(b_oen),
        .a_far(a_far), .b_far(b_far), .c_far(c_far), .a_ball(a_in), .b_ball(b_in),
        .c_ball(c_in));

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            complete_run;
        end
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one single word transfer; waits on the slave's ready, never on a fixed count
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        hwrite <= wr;
        hsize <= `PFM_HSIZE_WORD;
        htrans <= 2'h2;
        do @(posedge clk); while (hready_out !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready_out !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'(hresp), 32'h0);
    endtask : ahb

    task automatic do_reset(input logic [1:0] s);
        strap <= s;
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        ahb(1'b0, `PFM_OFF_SEL3, 32'h0, q);
        chk("sel3 reset", q, 32'h00000000);
        ahb(1'b0, `PFM_OFF_SEL4, 32'h0, q);
        chk("sel4 reset", q, 32'h00000000);
        ahb(1'b0, `PFM_OFF_SEL5, 32'h0, q);
        chk("sel5 reset", q, {s, 30'h0});
        chk("ddr map", 32'(ddr_map), 32'(s));
    endtask : do_reset

    function automatic int pix(input int k);
        return (k > 1 && k < 5) ? k + 1 : (k == 5) ? 2 : k;
    endfunction : pix

    // bank one bit of each ball of the second group
    function automatic int gbit(input int j);
        return (j < 4) ? 31 - j : (j == 7) ? 27 : 30 - j;
    endfunction : gbit

    // every field of both selects carries code c
    task automatic check_pads(input logic [1:0] c);
        logic [15:0] ao, ae, ai;
        logic [7:0] bo, be, b1, b2, m;
        logic [31:0] gs;
        logic lv;
        int g;
        gs = 32'h0;
        for (int k = 0; k < 16; k++) begin
            case (c)
                2'h0: {ao[k], ae[k]} = {gd[7 + k], gdo[7 + k]};
                2'h1: {ao[k], ae[k]} = {a_fo[k], a_foe[k]};
                2'h2: {ao[k], ae[k]} = {lcd[pix(k)], 1'b0};
                default: {ao[k], ae[k]} = {tv[pix(k)], 1'b0};
            endcase
            lv = ae[k] ? a_far[k] : ao[k];
            ai[k] = (c == 2'h1) ? lv : 1'b0;
            if (c == 2'h0) gs[7 + k] = lv;
        end
        for (int j = 0; j < 8; j++) begin
            g = gbit(j);
            {bo[j], be[j]} = 2'h1;
            if (c == 2'h0) {bo[j], be[j]} = {gd[g], gdo[g]};
            if (c == 2'h1) {bo[j], be[j]} = {f1o[j], (j == 7) ? 1'b1 : f1oe[j]};
            if (c == 2'h2 && j > 1) {bo[j], be[j]} = {f2o[j], f2oe[j]};
            lv = be[j] ? b_far[j] : bo[j];
            b1[j] = (c == 2'h1) ? lv : 1'b0;
            b2[j] = (c == 2'h2 && j > 1) ? lv : 1'b0;
            if (c == 2'h0) gs[g] = lv;
        end
        // a slave serial clock leaves the driven level open, only the release is fixed
        m = (c == 2'h1) ? 8'h7F : 8'hFF;
        chk("a_out", 32'(a_out), 32'(ao));
        chk("a_oen", 32'(a_oen), 32'(ae));
        chk("a_in", 32'(a_fi), 32'(ai));
        chk("b_out", 32'(b_out & m), 32'(bo & m));
        chk("b_oen", 32'(b_oen), 32'(be));
        chk("b_fn1", 32'(f1i), 32'(b1));
        chk("b_fn2", 32'(f2i), 32'(b2));
        chk("gpio", gsense, gs);
        chk("pclk", 32'({pclk_out, pclk_oen}),
            32'((c == 2'h2) ? {lcd_clk, 1'b0} : (c == 2'h3) ? {tv_clk, 1'b0} : 2'h1));
        chk("ddr map", 32'(ddr_map), 32'(c));
        chk("combo", 32'(c_cap), 32'(par_mode ? c_far : 6'h0));
    endtask : check_pads

    // far side and peripheral levels, inverted on the second pass
    task automatic drive(input logic [1:0] c, input logic p);
        logic [31:0] x;
        x = p ? 32'hFFFFFFFF : 32'h0;
        gd <= 32'hA5C33C5A ^ x;
        gdo <= 32'h0F0F00FF ^ x;
        a_fo <= 16'h3C96 ^ x[15:0];
        a_foe <= 16'h0FF0 ^ x[15:0];
        lcd <= 16'hB38E ^ x[15:0];
        tv <= 16'h4C71 ^ x[15:0];
        a_far <= 16'h6D29 ^ x[15:0];
        f1o <= 8'hC5 ^ x[7:0];
        f1oe <= 8'h0F ^ x[7:0];
        f2o <= 8'h3A ^ x[7:0];
        f2oe <= 8'h50 ^ x[7:0];
        b_far <= 8'h96 ^ x[7:0];
        c_far <= 6'h2B ^ x[5:0];
        lcd_clk <= ~p;
        tv_clk <= p;
        par_mode <= c[0] ^ p;
    endtask : drive

    initial begin
        {reset, hsel, hwrite, par_mode, lcd_clk, tv_clk, htrans, strap, hsize} = 13'h1000;
        {haddr, hwdata, gd, gdo, a_fo, a_foe, lcd, tv, a_far} = 208'h0;
        {f1o, f1oe, f2o, f2oe, b_far, c_far} = 46'h0;
        {n_errors, n_tests, cycles} = 0;
        do_reset(2'h1);
        // every bit stores, undefined codes and the reserved word included
        ahb(1'b1, `PFM_OFF_SEL3, 32'hC3A55A3C, q);
        ahb(1'b0, `PFM_OFF_SEL3, 32'h0, q);
        chk("sel3", q, 32'hC3A55A3C);
        ahb(1'b1, `PFM_OFF_SEL4, 32'h1234ABCD, q);
        ahb(1'b0, `PFM_OFF_SEL4, 32'h0, q);
        chk("sel4", q, 32'h1234ABCD);
        ahb(1'b1, `PFM_OFF_SEL5, 32'hFFFFF3FF, q);
        ahb(1'b0, `PFM_OFF_SEL5, 32'h0, q);
        chk("sel5", q, 32'hFFFFF3FF);
        ahb(1'b1, 12'h068, 32'hFFFFFFFF, q);
        ahb(1'b0, 12'h068, 32'h0, q);
        chk("unmapped", q, 32'h00000000);
        // capture clock two enable bit at 0x7c lives outside this block and must not land here
        ahb(1'b1, 12'h07C, 32'h00400000, q);
        ahb(1'b0, `PFM_OFF_SEL5, 32'h0, q);
        chk("sel5 after 7c", q, 32'hFFFFF3FF);
        for (int c = 0; c < 4; c++) begin
            for (int p = 0; p < 2; p++) begin
                drive(2'(c), 1'(p));
                ahb(1'b1, `PFM_OFF_SEL3, {16{2'(c)}}, q);
                // code 1 sets bit 8 too, so the serial clock ball is a slave input
                ahb(1'b1, `PFM_OFF_SEL5, {16{2'(c)}}, q);
                // select needs two cycles, a ball input three more through its sync
                repeat (8) @(posedge clk);
                check_pads(2'(c));
            end
        end
        do_reset(2'h2);
        complete_run;
    end
endmodule : pad_function_select_mux_bench

// ### pfm_ball_model.sv
// ball model: the package balls between the pad mux and the far-side parts
`timescale 1ns/10ps

module pfm_ball_model (
    input wire logic [15:0] a_out,
    input wire logic [15:0] a_oen,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oen,
    input wire logic [15:0] a_far,
    input wire logic [7:0] b_far,
    input wire logic [5:0] c_far,
    output logic [15:0] a_ball,
    output logic [7:0] b_ball,
    output logic [5:0] c_ball
);
    // a released ball shows the far-side driver, never the last mux value,
    // so a mux that forgets to release is seen at once
    assign a_ball = (a_out & ~a_oen) | (a_far & a_oen);
    assign b_ball = (b_out & ~b_oen) | (b_far & b_oen);
    // combo receive balls are inputs only
    assign c_ball = c_far;
endmodule : pfm_ball_model

// ### pfm_defines.svh
// register offsets, field positions, reset values and mux codes of the pad function mux
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH
`define PFM_OFF_SEL3 12'h05C
`define PFM_OFF_SEL4 12'h060
`define PFM_OFF_SEL5 12'h064
`define PFM_RST_SEL3 32'h00000000
`define PFM_RST_SEL4 32'h00000000
`define PFM_RST_SEL5 32'h00000000
`define PFM_HSIZE_WORD 3'h2
`define PFM_SEL_GPIO 2'h0
`define PFM_SEL_FUNC1 2'h1
`define PFM_SEL_FUNC2 2'h2
`define PFM_SEL_FUNC3 2'h3
`define PFM_A_GPIO_BASE 7
`define PFM_F5_MEMMAP 30
`define PFM_F5_USB_PLUS 18
`define PFM_F5_USB_MINUS 16
`define PFM_F5_PULSE_ONE 14
`define PFM_F5_PULSE_ZERO 12
`define PFM_F5_PCLK 8
`define PFM_F5_SLAVE_BIT 8
`define PFM_F5_SER_RX 6
`define PFM_F5_SER_TX 4
`define PFM_F5_SER_FRAME 2
`define PFM_F5_SER_CLOCK 0
`endif

// ### pfm_pad_mux.sv
// pad function mux: three select registers on AHB-Lite, registers three and five steering package balls
// Operation
// [RULE_01] field 31:30 routes spare pad 7: bank bit 22, card clock, lcd 15, tv 15
// [RULE_02] field 29:28 routes spare pad 6: bank bit 21, card data 0, lcd 14, tv 14
// [RULE_03] field 27:26 routes spare pad 5: bank bit 20, card data 1, lcd 13, tv 13
// [RULE_04] field 25:24 routes spare pad 4: bank bit 19, card detect, lcd 12, tv 12
// [RULE_05] field 23:22 routes phy reset ball: bit 18, reference clock in, pixel 11
// [RULE_06] field 21:20 routes transmit enable: bit 17, transmit enable, pixel 10
// [RULE_07] field 19:18 routes transmit data 1: bit 16, data, lcd 9 at 2, tv 9 at 3
// [RULE_08] field 17:16 routes transmit data 0: bit 15, data, pixel 8
// [RULE_09] field 15:14 routes phy clock output: bit 14, clock out, pixel 7
// [RULE_10] field 13:12 routes link indication: bit 13, link input, pixel 6
// [RULE_11] field 11:10 routes receive error: bit 12, error input, pixel 2
// [RULE_12] fields 9:8 and 7:6 route receive data 1 and 0, pixel 5 and 4
// [RULE_13] fields 5:4, 3:2, 1:0 route carrier sense, mdc, mdio, pixel 3, 1, 0
// [RULE_14] field 31:30 of register five picks memory map 0, 1 or 2
// [RULE_15] usb plus and minus balls: 0 bank bits 31 and 30, 1 usb lines
// [RULE_16] pulse balls: bank bit 29 or 28, pulse output, mic clock or data
// [RULE_17] pixel clock field: 0 unused, 1 nothing, 2 lcd clock, 3 tv clock
// [RULE_18] software sets bit 8 when the serial clock ball is a slave input
// [RULE_19] serial rx and clock balls: bank 26 or 27, serial, lcd sync
// [RULE_20] serial tx and frame balls: bank 25 or 24, serial, second uart
// [RULE_21] combo phy balls feed capture only while phy parallel mode is set
// [RULE_22] software sets bit 22 at 0x7c when raw clock is capture clock two
// [RULE_23] reset clears every mux field except the memory map selector
// [RULE_24] undefined encodings connect nothing but still store and read back
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`include "pfm_defines.svh"

module pfm_pad_mux (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [31:0] GPIO_DRIVE,
    input wire logic [31:0] GPIO_DRIVE_OEN,
    output logic [31:0] GPIO_SENSE,
    input wire logic [15:0] A_PAD_IN,
    output logic [15:0] A_PAD_OUT,
    output logic [15:0] A_PAD_OEN,
    input wire logic [15:0] A_FUNC_OUT,
    input wire logic [15:0] A_FUNC_OEN,
    output logic [15:0] A_FUNC_IN,
    input wire logic [15:0] LCD_PIXEL,
    input wire logic [15:0] TV_PIXEL,
    input wire logic [7:0] B_PAD_IN,
    output logic [7:0] B_PAD_OUT,
    output logic [7:0] B_PAD_OEN,
    input wire logic [7:0] B_FN1_OUT,
    input wire logic [7:0] B_FN1_OEN,
    output logic [7:0] B_FN1_IN,
    input wire logic [7:0] B_FN2_OUT,
    input wire logic [7:0] B_FN2_OEN,
    output logic [7:0] B_FN2_IN,
    input wire logic LCD_PIXEL_CLOCK,
    input wire logic TV_PIXEL_CLOCK,
    output logic PCLK_PAD_OUT,
    output logic PCLK_PAD_OEN,
    input wire logic PHY_PARALLEL_MODE,
    input wire logic [5:0] COMBO_PAD_IN,
    output logic [5:0] COMBO_CAPTURE,
    input wire logic [1:0] PKG_MAP_STRAP,
    output logic [1:0] DDR_MAP
);

    pfm_pkg::pfm_state_t st_r;
    pfm_pkg::pfm_state_t st_nxt;

    // pixel bit that a group a ball carries in lcd or tv mode
    function automatic int pix_index(input int k);
        case (k)
            0: pix_index = 0; // RULE_13
            1: pix_index = 1; // RULE_13
            2: pix_index = 3; // RULE_13
            3: pix_index = 4; // RULE_12
            4: pix_index = 5; // RULE_12
            5: pix_index = 2; // RULE_11
            6: pix_index = 6; // RULE_10
            7: pix_index = 7; // RULE_09
            8: pix_index = 8; // RULE_08
            9: pix_index = 9; // RULE_07
            10: pix_index = 10; // RULE_06
            11: pix_index = 11; // RULE_05
            12: pix_index = 12; // RULE_04
            13: pix_index = 13; // RULE_03
            14: pix_index = 14; // RULE_02
            default: pix_index = 15; // RULE_01
        endcase
    endfunction : pix_index

    // bank one bit that a group b ball carries in its default mode
    function automatic int b_gpio(input int j);
        case (j)
            0: b_gpio = 31; // RULE_15
            1: b_gpio = 30; // RULE_15
            2: b_gpio = 29; // RULE_16
            3: b_gpio = 28; // RULE_16
            4: b_gpio = 26; // RULE_19
            5: b_gpio = 25; // RULE_20
            6: b_gpio = 24; // RULE_20
            default: b_gpio = 27; // RULE_19
        endcase
    endfunction : b_gpio

    // low bit of the select field of a group b ball in register five
    function automatic int b_lsb(input int j);
        case (j)
            0: b_lsb = `PFM_F5_USB_PLUS;
            1: b_lsb = `PFM_F5_USB_MINUS;
            2: b_lsb = `PFM_F5_PULSE_ONE;
            3: b_lsb = `PFM_F5_PULSE_ZERO;
            4: b_lsb = `PFM_F5_SER_RX;
            5: b_lsb = `PFM_F5_SER_TX;
            6: b_lsb = `PFM_F5_SER_FRAME;
            default: b_lsb = `PFM_F5_SER_CLOCK;
        endcase
    endfunction : b_lsb

    // whole next state; pads use the registered selects so a write acts one cycle later
    always_comb begin
        pfm_pkg::pfm_reg_t dec;
        logic [1:0] s;
        int g;
        dec = pfm_pkg::PFM_REG_NONE;
        s = 2'h0;
        g = 0;
        st_nxt = st_r;
        st_nxt.ready = 1'b1;
        st_nxt.resp = 1'b0;
        // two-stage synchronisers for every pad and strap input
        st_nxt.a_s1 = A_PAD_IN;
        st_nxt.a_s2 = st_r.a_s1;
        st_nxt.b_s1 = B_PAD_IN;
        st_nxt.b_s2 = st_r.b_s1;
        st_nxt.c_s1 = COMBO_PAD_IN;
        st_nxt.c_s2 = st_r.c_s1;
        st_nxt.m_s1 = PKG_MAP_STRAP;
        st_nxt.m_s2 = st_r.m_s1;

        // data phase of a write: all bits stored, including undefined codes
        if (st_r.wr_pend) begin
            if (st_r.wr_sel == pfm_pkg::PFM_REG_THREE) begin
                st_nxt.sel3 = HWDATA; // RULE_24
            end else if (st_r.wr_sel == pfm_pkg::PFM_REG_FOUR) begin
                st_nxt.sel4 = HWDATA;
            end else if (st_r.wr_sel == pfm_pkg::PFM_REG_FIVE) begin
                st_nxt.sel5 = HWDATA;
            end
        end

        // address phase; reads see a write of the previous transfer
        st_nxt.wr_pend = 1'b0;
        st_nxt.wr_sel = pfm_pkg::PFM_REG_NONE;
        st_nxt.rdata = 32'h00000000;
        if (HSEL && HTRANS[1] && HREADY) begin
            if (HSIZE != `PFM_HSIZE_WORD) begin
                dec = pfm_pkg::PFM_REG_NONE;
            end else if (HADDR[11:0] == `PFM_OFF_SEL3) begin
                dec = pfm_pkg::PFM_REG_THREE;
            end else if (HADDR[11:0] == `PFM_OFF_SEL4) begin
                dec = pfm_pkg::PFM_REG_FOUR;
            end else if (HADDR[11:0] == `PFM_OFF_SEL5) begin
                dec = pfm_pkg::PFM_REG_FIVE;
            end
            if (HWRITE) begin
                st_nxt.wr_pend = (dec != pfm_pkg::PFM_REG_NONE);
                st_nxt.wr_sel = dec;
            end else if (dec == pfm_pkg::PFM_REG_THREE) begin
                st_nxt.rdata = st_nxt.sel3;
            end else if (dec == pfm_pkg::PFM_REG_FOUR) begin
                st_nxt.rdata = st_nxt.sel4;
            end else if (dec == pfm_pkg::PFM_REG_FIVE) begin
                st_nxt.rdata = st_nxt.sel5;
            end
        end

        // group a balls, one two-bit field each in register three
        st_nxt.gsense = 32'h00000000;
        for (int k = 0; k < 16; k++) begin
            s = st_r.sel3[2 * k +: 2];
            g = `PFM_A_GPIO_BASE + k;
            st_nxt.a_out[k] = 1'b0;
            st_nxt.a_oen[k] = 1'b1;
            st_nxt.a_fin[k] = 1'b0;
            case (s)
                `PFM_SEL_GPIO: begin
                    st_nxt.a_out[k] = GPIO_DRIVE[g];
                    st_nxt.a_oen[k] = GPIO_DRIVE_OEN[g];
                    st_nxt.gsense[g] = st_r.a_s2[k];
                end
                `PFM_SEL_FUNC1: begin
                    st_nxt.a_out[k] = A_FUNC_OUT[k];
                    st_nxt.a_oen[k] = A_FUNC_OEN[k];
                    st_nxt.a_fin[k] = st_r.a_s2[k];
                end
                `PFM_SEL_FUNC2: begin
                    st_nxt.a_out[k] = LCD_PIXEL[pix_index(k)];
                    st_nxt.a_oen[k] = 1'b0;
                end
                default: begin
                    // misprinted tv code 4 is taken as 3 on every ball
                    st_nxt.a_out[k] = TV_PIXEL[pix_index(k)]; // RULE_02
                    st_nxt.a_oen[k] = 1'b0; // RULE_04
                end
            endcase
        end

        // group b balls in register five; code 3 and usb code 2 drive nothing
        for (int j = 0; j < 8; j++) begin
            s = st_r.sel5[b_lsb(j) +: 2];
            g = b_gpio(j);
            st_nxt.b_out[j] = 1'b0;
            st_nxt.b_oen[j] = 1'b1;
            st_nxt.b_f1in[j] = 1'b0;
            st_nxt.b_f2in[j] = 1'b0;
            case (s)
                `PFM_SEL_GPIO: begin
                    st_nxt.b_out[j] = GPIO_DRIVE[g];
                    st_nxt.b_oen[j] = GPIO_DRIVE_OEN[g];
                    st_nxt.gsense[g] = st_r.b_s2[j];
                end
                `PFM_SEL_FUNC1: begin
                    st_nxt.b_out[j] = B_FN1_OUT[j];
                    st_nxt.b_oen[j] = B_FN1_OEN[j];
                    st_nxt.b_f1in[j] = st_r.b_s2[j];
                    // slave clock must not fight the external master
                    if (j == 7 && st_r.sel5[`PFM_F5_SLAVE_BIT]) begin
                        st_nxt.b_oen[j] = 1'b1; // RULE_18
                    end
                end
                `PFM_SEL_FUNC2: begin
                    if (j > 1) begin
                        st_nxt.b_out[j] = B_FN2_OUT[j]; // RULE_16
                        st_nxt.b_oen[j] = B_FN2_OEN[j]; // RULE_20
                        st_nxt.b_f2in[j] = st_r.b_s2[j]; // RULE_19
                    end
                end
                default: begin
                    st_nxt.b_oen[j] = 1'b1; // RULE_24
                end
            endcase
        end

        // pixel clock ball; codes 0 and 1 leave it undriven
        st_nxt.pclk_out = 1'b0;
        st_nxt.pclk_oen = 1'b1;
        if (st_r.sel5[`PFM_F5_PCLK +: 2] == `PFM_SEL_FUNC2) begin
            st_nxt.pclk_out = LCD_PIXEL_CLOCK; // RULE_17
            st_nxt.pclk_oen = 1'b0;
        end else if (st_r.sel5[`PFM_F5_PCLK +: 2] == `PFM_SEL_FUNC3) begin
            st_nxt.pclk_out = TV_PIXEL_CLOCK; // RULE_17
            st_nxt.pclk_oen = 1'b0;
        end

        // combo phy balls are analog lanes unless the phy is in parallel mode
        st_nxt.c_cap = PHY_PARALLEL_MODE ? st_r.c_s2 : 6'h00; // RULE_21

        // synchronous reset; map selector follows the strap instead of a constant
        if (RESET) begin
            st_nxt.sel3 = `PFM_RST_SEL3; // RULE_23
            st_nxt.sel4 = `PFM_RST_SEL4;
            st_nxt.sel5 = `PFM_RST_SEL5; // RULE_23
            st_nxt.sel5[`PFM_F5_MEMMAP +: 2] = st_r.m_s2; // RULE_14
            st_nxt.wr_pend = 1'b0;
            st_nxt.wr_sel = pfm_pkg::PFM_REG_NONE;
            st_nxt.rdata = 32'h00000000;
            st_nxt.a_out = 16'h0000;
            st_nxt.a_oen = 16'hFFFF;
            st_nxt.a_fin = 16'h0000;
            st_nxt.b_out = 8'h00;
            st_nxt.b_oen = 8'hFF;
            st_nxt.b_f1in = 8'h00;
            st_nxt.b_f2in = 8'h00;
            st_nxt.c_cap = 6'h00;
            st_nxt.gsense = 32'h00000000;
            st_nxt.pclk_out = 1'b0;
            st_nxt.pclk_oen = 1'b1;
        end
    end

    // the single state register
    always_ff @(posedge CLK) begin
        st_r <= st_nxt;
    end

    // every output taken straight from the state register
    assign HRDATA = st_r.rdata;
    assign HREADYOUT = st_r.ready;
    assign HRESP = st_r.resp;
    assign GPIO_SENSE = st_r.gsense;
    assign A_PAD_OUT = st_r.a_out;
    assign A_PAD_OEN = st_r.a_oen;
    assign A_FUNC_IN = st_r.a_fin;
    assign B_PAD_OUT = st_r.b_out;
    assign B_PAD_OEN = st_r.b_oen;
    assign B_FN1_IN = st_r.b_f1in;
    assign B_FN2_IN = st_r.b_f2in;
    assign PCLK_PAD_OUT = st_r.pclk_out;
    assign PCLK_PAD_OEN = st_r.pclk_oen;
    assign COMBO_CAPTURE = st_r.c_cap;
    assign DDR_MAP = st_r.sel5[`PFM_F5_MEMMAP +: 2];

    // checks on the mux behaviour
    a_reset_clears_sel: assert property (@(posedge CLK) // RULE_23
        RESET |=> (st_r.sel3 == 32'h00000000) && (st_r.sel5[29:0] == 30'h00000000))
        else $error("select fields not cleared by reset");

    a_mdio_gpio_path: assert property (@(posedge CLK) disable iff (RESET) // RULE_13
        !RESET && (st_r.sel3[1:0] == 2'h0) |=> (A_PAD_OUT[0] == $past(GPIO_DRIVE[7])))
        else $error("mdio ball not on bank bit 7");

    a_txd1_lcd_code: assert property (@(posedge CLK) disable iff (RESET) // RULE_07
        (st_r.sel3[19:18] == 2'h2) |=> (A_PAD_OUT[9] == $past(LCD_PIXEL[9])) && !A_PAD_OEN[9])
        else $error("transmit data 1 ball not on lcd bit 9");

    a_spare6_tv_code: assert property (@(posedge CLK) disable iff (RESET) // RULE_02
        (st_r.sel3[29:28] == 2'h3) |=> (A_PAD_OUT[14] == $past(TV_PIXEL[14])))
        else $error("spare pad 6 not on tv bit 14");

    a_rxer_lcd_bit: assert property (@(posedge CLK) disable iff (RESET) // RULE_11
        (st_r.sel3[11:10] == 2'h2) |=> (A_PAD_OUT[5] == $past(LCD_PIXEL[2])))
        else $error("receive error ball not on lcd bit 2");

    a_refclk_input: assert property (@(posedge CLK) disable iff (RESET) // RULE_05
        (st_r.sel3[23:22] == 2'h1) |=> (A_FUNC_IN[11] == $past(st_r.a_s2[11])))
        else $error("phy reset ball not routed to clock input");

    a_usb_undef_code: assert property (@(posedge CLK) disable iff (RESET) // RULE_24
        (st_r.sel5[19:18] == 2'h2) |=> B_PAD_OEN[0] && !B_FN1_IN[0] && !B_FN2_IN[0])
        else $error("undefined usb code connected a function");

    a_mic_data_in: assert property (@(posedge CLK) disable iff (RESET) // RULE_16
        (st_r.sel5[13:12] == 2'h2) |=> (B_FN2_IN[3] == $past(st_r.b_s2[3])))
        else $error("pulse ball 0 not routed to mic data");

    a_pclk_tv_drive: assert property (@(posedge CLK) disable iff (RESET) // RULE_17
        (st_r.sel5[9:8] == 2'h3) |=> !PCLK_PAD_OEN && (PCLK_PAD_OUT == $past(TV_PIXEL_CLOCK)))
        else $error("pixel clock ball not on tv clock");

    a_sclk_slave_oe: assert property (@(posedge CLK) disable iff (RESET) // RULE_18
        (st_r.sel5[1:0] == 2'h1) && st_r.sel5[8] |=> B_PAD_OEN[7])
        else $error("slave serial clock ball driven");

    a_combo_gate_off: assert property (@(posedge CLK) disable iff (RESET) // RULE_21
        !PHY_PARALLEL_MODE |=> (COMBO_CAPTURE == 6'h00))
        else $error("combo balls reached capture outside parallel mode");

    a_write_then_map: assert property (@(posedge CLK) disable iff (RESET) // RULE_14
        st_r.wr_pend && (st_r.wr_sel == pfm_pkg::PFM_REG_FIVE) |=> (DDR_MAP == $past(HWDATA[31:30])))
        else $error("memory map field not written");

endmodule : pfm_pad_mux

// ### pfm_pkg.sv
// types shared by the pad function mux
package pfm_pkg;
    typedef enum logic [1:0] {
        PFM_REG_NONE = 2'h0,
        PFM_REG_THREE = 2'h1,
        PFM_REG_FOUR = 2'h2,
        PFM_REG_FIVE = 2'h3
    } pfm_reg_t;

    typedef struct packed {
        logic [31:0] sel3;
        logic [31:0] sel4;
        logic [31:0] sel5;
        logic wr_pend;
        pfm_reg_t wr_sel;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic [15:0] a_s1;
        logic [15:0] a_s2;
        logic [15:0] a_out;
        logic [15:0] a_oen;
        logic [15:0] a_fin;
        logic [7:0] b_s1;
        logic [7:0] b_s2;
        logic [7:0] b_out;
        logic [7:0] b_oen;
        logic [7:0] b_f1in;
        logic [7:0] b_f2in;
        logic [5:0] c_s1;
        logic [5:0] c_s2;
        logic [5:0] c_cap;
        logic [1:0] m_s1;
        logic [1:0] m_s2;
        logic [31:0] gsense;
        logic pclk_out;
        logic pclk_oen;
    } pfm_state_t;
endpackage : pfm_pkg
